// *** common/fpes_pkg.sv ***
package fpes_pkg;

  // register map, byte addresses inside the slave
  localparam logic [7:0]  OFS_CTRL_ONE  = 8'h00;
  localparam logic [7:0]  OFS_CTRL_TWO  = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam int          ARR_SEL_BIT   = 18;   // haddr bit that selects the array window
  localparam int          INTERNAL_ARRAY_ADDRESS_W       = 18;   // internal array address width

  // control register one field positions
  localparam int CO_PROT_LSB  = 24;
  localparam int CO_CSC_LSB   = 22;
  localparam int CO_SIE_BIT   = 21;
  localparam int CO_SCLK_LSB  = 16;
  localparam int CO_PULSE_EXPONENT_LSB = 8;
  localparam int CO_PERIOD_MULTIPLIER_LSB = 0;

  // hv control register two field positions
  localparam int CT_BLOCK_LSB = 8;
  localparam int CT_MON_BIT   = 5;
  localparam int CT_B0M_BIT   = 4;
  localparam int CT_OPS_BIT   = 2;
  localparam int CT_SEQ_BIT   = 1;
  localparam int CT_HVE_BIT   = 0;

  // status register bit positions
  localparam int ST_HVS_BIT   = 0;
  localparam int ST_PULSE_BIT = 1;
  localparam int ST_RAMP_BIT  = 2;
  localparam int ST_PVAL_BIT  = 3;
  localparam int ST_ELCK_BIT  = 4;

  // internal array address fields
  localparam int IA_WORD_LSB  = 2;
  localparam int IA_WORD_W    = 4;
  localparam int IA_PAGE_LSB  = 6;
  localparam int IA_PAGE_W    = 8;
  localparam int IA_BLK_LSB   = 14;
  localparam int IA_BLK_W     = 3;

  // reset values
  localparam logic [31:0] CTRL_ONE_RST  = 32'h0000_0000;
  localparam logic [15:0] CTRL_TWO_RST  = 16'h0000;

  // orderly high voltage shutdown time
  localparam int SHUT_NS      = 500;
  localparam int CLK_MHZ      = 40;
  localparam int SHUT_CYCLES  = (SHUT_NS * CLK_MHZ + 999) / 1000;
  localparam int SHUT_CNT_W   = 6;

  typedef enum logic [1:0] {
    FPES_HV_IDLE = 2'b00,
    FPES_HV_PULSE = 2'b01,
    FPES_HV_SHUT = 2'b10
  } fpes_hv_e;

endpackage

// *** common/fpes_buf_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fpes_buf_if #(
  parameter int AW = 7,
  parameter int DW = 32
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem   (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// *** rtl/fpes_page_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpes_page_buf #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  input wire logic sys_clk,    // system clock
  input wire logic srst,       // synchronous reset
  input wire logic release_buf, // clear all words
  fpes_buf_if.mem  bif         // write and read port
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rdata;
  } fpes_buf_s;

  fpes_buf_s st;
  fpes_buf_s next_st;

  // write port and registered read port; releasing wipes old data
  always_comb begin
    next_st = st;
    next_st.rdata = st.mem[bif.raddr];
    if (release_buf) begin
      next_st.mem = '0;
    end else if (bif.we) begin
      next_st.mem[bif.waddr] = bif.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bif.rdata = st.rdata;

endmodule
`default_nettype wire

// *** rtl/fpes_top.sv ***
// Function
// - writes to operation select are ignored while sequence active is set
// - operation select zero means program, one means erase
// - program mode with sequence active locks shadow enable; erase mode does not
// - sequence active writes ignored while hv status or hv enable is set
// - sequence active locks protect, block, censor, op select and timing fields
// - in erase mode any array write after sequence start is the interlock write
// - first program write latches page offset and loads its buffer word
// - later program writes fill buffer chosen by low and block address bits
// - setting hv enable starts the pulse and rejects further program writes
// - erase needs the interlock write before hv enable may be set
// - clearing sequence active releases buffers and all locked fields
// - hv enable stays zero without sequence active and a valid write
// - high voltage is applied only with hv enable and enable monitor set
// - while hv enable is set sequence active is frozen and array reads stall
// - hv enable resets to zero so no pulse runs out of reset
// - master reset ends high voltage and restores the whole register
// - system reset request or stop clears hv enable and ends the pulse
// - a terminated pulse always passes through an orderly ramp down
// - monitor captures filtered enable at hv rise; filter needs two equal samples
// - block select picks up to eight blocks, one bit each
`timescale 1ns/1ps
`default_nettype none
module fpes_top #(
  parameter int BUF_AW = 7,
  parameter int SHUT_CYC = fpes_pkg::SHUT_CYCLES
) (
  input  wire logic        sys_clk,        // system clock, 40 MHz
  input  wire logic        srst,           // master reset, synchronous, high
  input  wire logic        hsel,           // ahb slave select
  input  wire logic [31:0] haddr,          // ahb address
  input  wire logic [1:0]  htrans,         // ahb transfer type
  input  wire logic        hwrite,         // ahb write
  input  wire logic [2:0]  hsize,          // ahb size, word only
  input  wire logic        hready,         // ahb bus ready
  input  wire logic [31:0] hwdata,         // ahb write data
  output logic [31:0]      hrdata,         // ahb read data
  output logic             hreadyout,      // ahb slave ready
  output logic             hresp,          // ahb response, always okay
  input  wire logic        sys_reset_req,  // system reset, clears hv enable
  input  wire logic        stop_req,       // module stop bit
  input  wire logic        prog_enable_in, // raw program enable signal
  input  wire logic        block0_enable_in, // raw block zero enable signal
  input  wire logic [31:0] arr_rdata,      // array read data for normal reads
  input  wire logic [BUF_AW-1:0] buf_raddr, // buffer read address from hv circuitry
  output logic [31:0]      buf_rdata,      // buffer read data, registered
  output logic             hv_pulse,       // high voltage applied
  output logic             hv_ramp_down,   // orderly shutdown in progress
  output logic [7:0]       block_select,   // blocks selected for the operation
  output logic             erase_mode,     // operation select
  output logic [7:0]       page_offset     // latched program page offset
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  localparam int INTERNAL_ARRAY_ADDRESS_LOCAL = fpes_pkg::INTERNAL_ARRAY_ADDRESS_W;
  localparam logic [fpes_pkg::SHUT_CNT_W-1:0] SHUT_CNT_LOAD = SHUT_CYC[fpes_pkg::SHUT_CNT_W-1:0];

  typedef struct packed {
    logic [7:0]  protect;
    logic [1:0]  censor_control;
    logic        shadow_enable;
    logic [2:0]  clock_range_select;
    logic [1:0]  pulse_exponent;
    logic [6:0]  period_multiplier;
    logic [7:0]  block_sel;
    logic        enable_monitor;
    logic        block_zero_monitor;
    logic        op_select_erase;
    logic        sequence_active;
    logic        hv_enable;
    logic        first_done;
    logic        prog_valid;
    logic        erase_lock;
    logic [7:0]  page_off;
    fpes_pkg::fpes_hv_e hv_state;
    logic [fpes_pkg::SHUT_CNT_W-1:0] shut_cnt;
    logic        pulse;
    logic        pe_last;
    logic        pe_filt;
    logic        b0_last;
    logic        b0_filt;
    logic        dp_valid;
    logic        dp_write;
    logic [fpes_pkg::ARR_SEL_BIT:0] dp_addr;
    logic        rd_done;
    logic [31:0] rdata;
  } fpes_state_s;

  fpes_state_s st;
  fpes_state_s next_st;
  fpes_state_s rst_st;

  logic              buf_we;
  logic [BUF_AW-1:0] buf_waddr;
  logic [31:0]       buf_wdata;
  logic              buf_release;

  fpes_buf_if #(.AW(BUF_AW), .DW(32)) bif ();

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_array(input logic [fpes_pkg::ARR_SEL_BIT:0] a);
    return a[fpes_pkg::ARR_SEL_BIT];
  endfunction

  function automatic logic [15:0] pack_ctrl_two(input fpes_state_s s);
    logic [15:0] v;
    v = fpes_pkg::CTRL_TWO_RST;
    v[fpes_pkg::CT_BLOCK_LSB +: 8] = s.block_sel;
    v[fpes_pkg::CT_MON_BIT] = s.enable_monitor;
    v[fpes_pkg::CT_B0M_BIT] = s.block_zero_monitor;
    v[fpes_pkg::CT_OPS_BIT] = s.op_select_erase;
    v[fpes_pkg::CT_SEQ_BIT] = s.sequence_active;
    v[fpes_pkg::CT_HVE_BIT] = s.hv_enable;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        hv_status;
    logic [7:0]  ofs;
    logic [INTERNAL_ARRAY_ADDRESS_LOCAL-1:0] ia;
    logic [31:0] rv;
    logic        wr_phase;
    hv_status = 1'b0;
    ofs = 8'h00;
    ia = '0;
    rv = 32'h0000_0000;
    wr_phase = 1'b0;
    next_st = st;
    buf_we = 1'b0;
    buf_waddr = '0;
    buf_wdata = hwdata;
    buf_release = 1'b0;

    hv_status = (st.hv_state != fpes_pkg::FPES_HV_IDLE);
    ofs = st.dp_addr[7:0];
    ia = st.dp_addr[INTERNAL_ARRAY_ADDRESS_LOCAL-1:0];
    wr_phase = st.dp_valid && st.dp_write;

    // enable filters: output follows only after two equal samples in a row
    next_st.pe_last = prog_enable_in;
    next_st.b0_last = block0_enable_in;
    if (prog_enable_in == st.pe_last) begin
      next_st.pe_filt = prog_enable_in;
    end
    if (block0_enable_in == st.b0_last) begin
      next_st.b0_filt = block0_enable_in;
    end

    // register writes; locked fields keep their value and the bus still sees okay
    if (wr_phase && !is_array(st.dp_addr)) begin
      unique case (ofs)
        fpes_pkg::OFS_CTRL_ONE: begin
          if (!st.sequence_active) begin
            next_st.protect = hwdata[fpes_pkg::CO_PROT_LSB +: 8];
            next_st.censor_control = hwdata[fpes_pkg::CO_CSC_LSB +: 2];
            next_st.clock_range_select = hwdata[fpes_pkg::CO_SCLK_LSB +: 3];
            next_st.pulse_exponent = hwdata[fpes_pkg::CO_PULSE_EXPONENT_LSB +: 2];
            next_st.period_multiplier = hwdata[fpes_pkg::CO_PERIOD_MULTIPLIER_LSB +: 7];
          end
          if (!(st.sequence_active && !st.op_select_erase)) begin
            next_st.shadow_enable = hwdata[fpes_pkg::CO_SIE_BIT];
          end
        end
        fpes_pkg::OFS_CTRL_TWO: begin
          if (!st.sequence_active) begin
            next_st.block_sel = hwdata[fpes_pkg::CT_BLOCK_LSB +: 8];
            next_st.op_select_erase = hwdata[fpes_pkg::CT_OPS_BIT];
          end
          if (!hv_status && !st.hv_enable) begin
            next_st.sequence_active = hwdata[fpes_pkg::CT_SEQ_BIT];
          end
          if (!hwdata[fpes_pkg::CT_HVE_BIT]) begin
            next_st.hv_enable = 1'b0;
          end else if (st.sequence_active &&
                       (st.op_select_erase ? st.erase_lock : st.prog_valid)) begin
            next_st.hv_enable = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // array writes during a sequence; none are taken once the pulse is enabled
    if (wr_phase && is_array(st.dp_addr) && st.sequence_active && !st.hv_enable) begin
      if (st.op_select_erase) begin
        next_st.erase_lock = 1'b1;
      end else begin
        buf_we = 1'b1;
        buf_waddr = {ia[fpes_pkg::IA_BLK_LSB +: fpes_pkg::IA_BLK_W],
                     ia[fpes_pkg::IA_WORD_LSB +: fpes_pkg::IA_WORD_W]};
        next_st.prog_valid = 1'b1;
        if (!st.first_done) begin
          next_st.first_done = 1'b1;
          next_st.page_off = ia[fpes_pkg::IA_PAGE_LSB +: fpes_pkg::IA_PAGE_W];
        end
      end
    end

    // ending the sequence frees buffers and interlock state
    if (st.sequence_active && !next_st.sequence_active) begin
      next_st.first_done = 1'b0;
      next_st.prog_valid = 1'b0;
      next_st.erase_lock = 1'b0;
      next_st.page_off = 8'h00;
      buf_release = 1'b1;
      buf_we = 1'b0;
    end

    // system reset request and stop win over any write of hv enable
    if (sys_reset_req || stop_req) begin
      next_st.hv_enable = 1'b0;
    end

    // monitors sample the filters on the rising edge of hv enable, cleared on its fall
    if (next_st.hv_enable && !st.hv_enable) begin
      next_st.enable_monitor = st.pe_filt;
      next_st.block_zero_monitor = st.b0_filt;
    end else if (!next_st.hv_enable) begin
      next_st.enable_monitor = 1'b0;
      next_st.block_zero_monitor = 1'b0;
    end

    // pulse sequencer; every end of a pulse goes through ramp down, never a hard cut
    unique case (st.hv_state)
      fpes_pkg::FPES_HV_IDLE: begin
        if (next_st.hv_enable) begin
          next_st.hv_state = fpes_pkg::FPES_HV_PULSE;
        end
      end
      fpes_pkg::FPES_HV_PULSE: begin
        if (!next_st.hv_enable) begin
          next_st.hv_state = fpes_pkg::FPES_HV_SHUT;
          next_st.shut_cnt = SHUT_CNT_LOAD;
        end
      end
      fpes_pkg::FPES_HV_SHUT: begin
        if (st.shut_cnt == '0) begin
          next_st.hv_state = fpes_pkg::FPES_HV_IDLE;
        end else begin
          next_st.shut_cnt = st.shut_cnt - 1'b1;
        end
      end
      default: begin
        next_st.hv_state = fpes_pkg::FPES_HV_IDLE;
      end
    endcase
    next_st.pulse = (next_st.hv_state == fpes_pkg::FPES_HV_PULSE) &&
                    next_st.hv_enable && next_st.enable_monitor;

    // read data phase: one wait state, array reads held off while hv enable is set
    if (st.dp_valid && !st.dp_write && !st.rd_done) begin
      if (is_array(st.dp_addr)) begin
        if (!st.hv_enable) begin
          next_st.rdata = arr_rdata;
          next_st.rd_done = 1'b1;
        end
      end else begin
        unique case (ofs)
          fpes_pkg::OFS_CTRL_ONE: begin
            rv[fpes_pkg::CO_PROT_LSB +: 8] = st.protect;
            rv[fpes_pkg::CO_CSC_LSB +: 2] = st.censor_control;
            rv[fpes_pkg::CO_SIE_BIT] = st.shadow_enable;
            rv[fpes_pkg::CO_SCLK_LSB +: 3] = st.clock_range_select;
            rv[fpes_pkg::CO_PULSE_EXPONENT_LSB +: 2] = st.pulse_exponent;
            rv[fpes_pkg::CO_PERIOD_MULTIPLIER_LSB +: 7] = st.period_multiplier;
          end
          fpes_pkg::OFS_CTRL_TWO: begin
            rv = {16'h0000, pack_ctrl_two(st)};
          end
          fpes_pkg::OFS_STATUS: begin
            rv[fpes_pkg::ST_HVS_BIT] = hv_status;
            rv[fpes_pkg::ST_PULSE_BIT] = st.pulse;
            rv[fpes_pkg::ST_RAMP_BIT] = (st.hv_state == fpes_pkg::FPES_HV_SHUT);
            rv[fpes_pkg::ST_PVAL_BIT] = st.prog_valid;
            rv[fpes_pkg::ST_ELCK_BIT] = st.erase_lock;
          end
          default: begin
            rv = 32'h0000_0000; // unmapped reads return zero
          end
        endcase
        next_st.rdata = rv;
        next_st.rd_done = 1'b1;
      end
    end

    // bus pipeline: a data phase ends when this slave is ready
    if (hreadyout) begin
      next_st.dp_valid = 1'b0;
      next_st.rd_done = 1'b0;
    end
    if (hready && hsel && htrans[1]) begin
      next_st.dp_valid = 1'b1;
      next_st.dp_write = hwrite;
      next_st.dp_addr = haddr[fpes_pkg::ARR_SEL_BIT:0];
      next_st.rd_done = 1'b0;
    end

    // master reset still ramps a live pulse down; a hard cut could harm the pump
    rst_st = '0;
    if (st.hv_state == fpes_pkg::FPES_HV_PULSE) begin
      rst_st.hv_state = fpes_pkg::FPES_HV_SHUT;
      rst_st.shut_cnt = SHUT_CNT_LOAD;
    end else if (st.hv_state == fpes_pkg::FPES_HV_SHUT) begin
      rst_st.hv_state = next_st.hv_state;
      rst_st.shut_cnt = next_st.shut_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  // master reset zeroes the register set, hv enable included; only a ramp runs on
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= rst_st;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer memory and outputs

  assign bif.we    = buf_we;
  assign bif.waddr = buf_waddr;
  assign bif.wdata = buf_wdata;
  assign bif.raddr = buf_raddr;

  fpes_page_buf #(.AW(BUF_AW), .DW(32)) u_buf (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .release_buf (buf_release),
    .bif         (bif)
  );

  // read data phase stalls until data is loaded; writes take no wait state
  assign hreadyout    = !(st.dp_valid && !st.dp_write && !st.rd_done);
  assign hresp        = 1'b0; // locked writes still answer okay
  assign hrdata       = st.rdata;
  assign buf_rdata    = bif.rdata;
  assign hv_pulse     = st.pulse;
  assign hv_ramp_down = (st.hv_state == fpes_pkg::FPES_HV_SHUT);
  assign block_select = st.block_sel & {7'h7f, st.block_zero_monitor | !st.hv_enable};
  assign erase_mode   = st.op_select_erase;
  assign page_offset  = st.page_off;

endmodule
`default_nettype wire

// *** tb/fpes_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// bus master standing in for processor software
module fpes_host_model (
  input  wire logic        sys_clk, // system clock
  input  wire logic        hready,  // bus ready
  input  wire logic [31:0] hrdata,  // read data
  output logic             hsel,    // slave select
  output logic [31:0]      haddr,   // address
  output logic [1:0]       htrans,  // transfer type
  output logic             hwrite,  // write strobe
  output logic [2:0]       hsize,   // word size
  output logic [31:0]      hwdata   // write data
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end
  // one single word transfer; no wait count is assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
    // released data must never look like a fresh value
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

// *** tb/fpes_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpes_chk #(
  parameter int SHUT_CYC = fpes_pkg::SHUT_CYCLES
) (
  input wire logic        sys_clk,       // clock
  input wire logic        srst,          // master reset
  input wire logic        hsel,          // select
  input wire logic [31:0] haddr,         // address
  input wire logic [1:0]  htrans,        // transfer type
  input wire logic        hwrite,        // write
  input wire logic        hready,        // bus ready
  input wire logic        hreadyout,     // slave ready
  input wire logic        hresp,         // response
  input wire logic        stop_req,      // module stop
  input wire logic        sys_reset_req, // system reset
  input wire logic        hv_pulse,      // pulse applied
  input wire logic        hv_ramp_down,  // shutdown phase
  input wire logic [7:0]  block_select,  // blocks
  input wire logic        erase_mode,    // op select
  input wire logic [7:0]  page_offset    // page offset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // counts shutdown length so a short ramp cannot slip by; runs on through reset
  logic [7:0] ramp_cnt;
  always_ff @(posedge sys_clk) begin
    if (!hv_ramp_down) ramp_cnt <= 8'h00;
    else ramp_cnt <= ramp_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  sequence s_take; hsel && htrans[1] && hready; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  property p_hresp; !hresp; endproperty
  property p_write_ok; s_take ##0 hwrite |=> hreadyout; endproperty
  property p_reg_rd;
    s_take ##0 (!hwrite && !haddr[fpes_pkg::ARR_SEL_BIT]) |=> s_one_wait;
  endproperty
  property p_arr_stall;
    s_take ##0 (!hwrite && haddr[fpes_pkg::ARR_SEL_BIT] && hv_pulse) |=> !hreadyout;
  endproperty
  property p_stop; (stop_req || sys_reset_req) |-> ##[1:3] !hv_pulse; endproperty
  property p_fall_ramp; $fell(hv_pulse) |-> ##[0:2] hv_ramp_down; endproperty
  property p_ramp_len; $fell(hv_ramp_down) |-> ramp_cnt == 8'(SHUT_CYC + 1); endproperty
  property p_lock;
    (page_offset != 8'h00 && $past(page_offset) != 8'h00)
      |-> $stable(erase_mode) && $stable(block_select[7:1]);
  endproperty
  property p_mode_prog; page_offset != 8'h00 |-> !erase_mode; endproperty
  a_hresp: assert property (p_hresp) else $error("error response seen");
  a_write_ok: assert property (p_write_ok) else $error("write stalled");
  a_reg_rd: assert property (p_reg_rd) else $error("register read timing");
  a_arr_stall: assert property (p_arr_stall) else $error("array read acked");
  a_stop: assert property (p_stop) else $error("pulse kept after stop");
  a_fall_ramp: assert property (p_fall_ramp) else $error("abrupt pulse end");
  a_ramp_len: assert property (p_ramp_len) else $error("ramp length wrong");
  a_lock: assert property (p_lock) else $error("locked field moved");
  a_mode_prog: assert property (p_mode_prog) else $error("page in erase");
endmodule
bind fpes_top fpes_chk #(.SHUT_CYC(SHUT_CYC)) u_chk (.sys_clk(sys_clk), .srst(srst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .stop_req(stop_req),
  .sys_reset_req(sys_reset_req), .hv_pulse(hv_pulse), .hv_ramp_down(hv_ramp_down),
  .block_select(block_select), .erase_mode(erase_mode), .page_offset(page_offset));
`default_nettype wire

// *** tb/fpes_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpes_top_tb_top;
  localparam logic [31:0] A1 = {24'h00_0000, fpes_pkg::OFS_CTRL_ONE};
  localparam logic [31:0] A2 = {24'h00_0000, fpes_pkg::OFS_CTRL_TWO};
  localparam logic [31:0] A3 = {24'h00_0000, fpes_pkg::OFS_STATUS};
  localparam logic [31:0] ARR = 32'h0004_0000;
  localparam logic [31:0] M1 = 32'hFFE7_037F;
  logic sys_clk = 1'b0, srst, sys_reset_req, stop_req, prog_enable_in, block0_enable_in;
  logic hsel, hwrite, hreadyout, hresp, hv_pulse, hv_ramp_down, erase_mode;
  logic [31:0] haddr, hwdata, hrdata, arr_rdata, buf_rdata, v, c1, d0, ad;
  logic [1:0] htrans;
  logic [2:0] hsize, b0;
  logic [3:0] w0;
  logic [6:0] buf_raddr;
  logic [7:0] block_select, page_offset, pg;
  int errors, checks, i, k;
  always #12.5 sys_clk = ~sys_clk;
  fpes_host_model host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  fpes_top #(.BUF_AW(7), .SHUT_CYC(8)) uut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sys_reset_req(sys_reset_req), .stop_req(stop_req), .prog_enable_in(prog_enable_in),
    .block0_enable_in(block0_enable_in), .arr_rdata(arr_rdata), .buf_raddr(buf_raddr),
    .buf_rdata(buf_rdata), .hv_pulse(hv_pulse), .hv_ramp_down(hv_ramp_down),
    .block_select(block_select), .erase_mode(erase_mode), .page_offset(page_offset));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] aaddr(input logic [2:0] b, input logic [7:0] p,
                                        input logic [3:0] w);
    return ARR | {15'h0000, b, p, w, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask
  // buffer read port has one cycle of latency
  task automatic bchk(input logic [6:0] idx, input logic [31:0] e);
    buf_raddr <= idx;
    repeat (2) @(posedge sys_clk);
    chk(buf_rdata, e);
  endtask
  task automatic conclude;
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    conclude();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {srst, sys_reset_req, stop_req, prog_enable_in, block0_enable_in} = 5'b10010;
    arr_rdata = 32'h0000_0000;
    buf_raddr = 7'h00;
    errors = 0;
    checks = 0;
    void'($urandom(69208));
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(A2, 32'h0000_0000);
    rd(A3, 32'h0000_0000);
    wr(32'h0000_000C, 32'hFFFF_FFFF);
    rd(32'h0000_000C, 32'h0000_0000);
    // free configuration while no sequence runs
    for (i = 0; i < 6; i++) begin
      v = $urandom;
      wr(A1, v);
      c1 = v & M1;
      rd(A1, c1);
      v = $urandom & 32'h0000_FF04;
      wr(A2, v);
      rd(A2, v);
      chk(32'(erase_mode), 32'(v[2]));
      chk(32'(block_select), 32'(v[15:8]));
    end
    // program sequence; early enable writes are refused
    wr(A2, 32'h0000_0503);
    rd(A2, 32'h0000_0502);
    wr(A2, 32'h0000_0503);
    rd(A2, 32'h0000_0502);
    wr(A2, 32'h0000_A006);
    rd(A2, 32'h0000_0502);
    wr(A1, ~c1);
    rd(A1, c1);
    pg = 8'($urandom) | 8'h01;
    b0 = 3'($urandom);
    w0 = 4'($urandom);
    d0 = $urandom;
    v = $urandom;
    wr(aaddr(b0, pg, w0), d0);
    wr(aaddr(b0 + 3'h1, pg ^ 8'h5A, w0 + 4'h3), v);
    chk(32'(page_offset), 32'(pg));
    bchk({b0, w0}, d0);
    bchk({b0 + 3'h1, w0 + 4'h3}, v);
    wr(A2, 32'h0000_0503);
    rd(A2, 32'h0000_0523);
    chk(32'(hv_pulse), 32'h0000_0001);
    chk(32'(block_select), 32'h0000_0004);
    wr(aaddr(b0, pg, w0), ~d0);
    bchk({b0, w0}, d0);
    wr(A2, 32'h0000_0001);
    rd(A2, 32'h0000_0523);
    wr(A2, 32'h0000_0502);
    wr(A2, 32'h0000_0500);
    rd(A2, 32'h0000_0502);
    repeat (12) @(posedge sys_clk);
    wr(A2, 32'h0000_0000);
    rd(A2, 32'h0000_0500);
    chk(32'(page_offset), 32'h0000_0000);
    bchk({b0, w0}, 32'h0000_0000);
    wr(A1, ~c1);
    c1 = ~c1 & M1;
    rd(A1, c1);
    // erase sequences ended by stop and by system reset
    for (k = 0; k < 2; k++) begin
      prog_enable_in <= k[0];
      wr(A2, 32'h0000_0F06);
      wr(A2, 32'h0000_0F07);
      rd(A2, 32'h0000_0F06);
      wr(A1, ~c1);
      c1 = c1 ^ 32'h0020_0000;
      rd(A1, c1);
      wr(aaddr(3'($urandom), 8'($urandom), 4'($urandom)), $urandom);
      rd(A3, 32'h0000_0010);
      wr(A2, 32'h0000_0F07);
      rd(A2, k ? 32'h0000_0F27 : 32'h0000_0F07);
      chk(32'(hv_pulse), 32'(k));
      ad = $urandom;
      arr_rdata <= ad;
      fork
        rd(ARR, ad);
        begin
          repeat (6) @(posedge sys_clk);
          chk(32'(hreadyout), 32'h0000_0000);
          if (k == 0) stop_req <= 1'b1;
          else sys_reset_req <= 1'b1;
          @(posedge sys_clk);
          stop_req <= 1'b0;
          sys_reset_req <= 1'b0;
        end
      join
      rd(A2, 32'h0000_0F06);
      repeat (12) @(posedge sys_clk);
      wr(A2, 32'h0000_0F04);
    end
    // master reset in the middle of a pulse
    wr(A2, 32'h0000_0306);
    wr(ARR, $urandom);
    wr(A2, 32'h0000_0307);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    chk(32'(hv_ramp_down), 32'h0000_0001);
    rd(A2, 32'h0000_0000);
    rd(A1, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
